// ---- eeprom_write_ctrl.sv ----
// Purpose: Write command logic of a two-wire serial EEPROM with ident page and soft protect
// Assumes: SCL is the link clock; SDA is open drain, resolved outside
// Notes:   Programming is committed when the self-timed cycle ends
// How it works
// - Write starts with start, type 1010, address bits, select zero; acknowledged on ninth clock.
// - Pin high or soft protect set: data bytes not acknowledged, nothing changes.
// - Pin low and soft protect clear: every memory write data byte is acknowledged.
// - Byte write programs only on a stop in the tenth clock.
// - During the write cycle all bus activity is ignored.
// - The address counter advances by one for each written byte.
// - Page write withholds the stop and sends up to sixteen bytes.
// - Under protection no page byte is acknowledged or stored.
// - Only the low four address bits increment, wrapping inside the page.
// - Beyond sixteen bytes, later bytes overwrite earlier buffered ones.
// - Page write programs only on a stop right after the last acknowledge.
// - Address bytes are refused while busy and acknowledged once done.
// - Cycle time runs from the valid stop until the self-timed WR_CYCLES count expires.
// - Ident page write uses type 1011, select bits 00, low nibble as byte.
// - A locked ident page refuses its write data bytes.
// - Lock command: type 1011, select 10, data bit one set, held until the next reset.
// - After locking, later lock data bytes are refused.
// - Soft protect write: type 1011, select 11, data bit zero is the value.
// - A second soft protect data byte cancels the write and keeps the bit.
// - Soft protect writes work whatever the protect pin level.
// - Read address bytes of either type are acknowledged regardless of protection.
// - Mismatched address bytes get no acknowledge; the device goes to standby.
// - Select bit one means read, zero write; bits arrive MSB first.
`timescale 1ns/100ps
`default_nettype none

module eeprom_write_ctrl #(
    parameter int WR_CYCLES = eeprom_wr_pkg::WR_CYCLES_DEF  // Self-timed write length in cycles
)(
    input  wire logic        clock_i,        // System clock
    input  wire logic        nrst_i,         // Reset, active low; synchronous, but asynchronous for the link-domain flops
    input  wire logic        scl_i,          // Bus clock, link domain
    input  wire logic        sda_i,          // Bus data level
    input  wire logic        wp_i,           // Hardware write protect pin
    input  wire logic [10:0] rd_addr_i,      // Array inspection address
    output logic             sda_o,          // Data drive value, always low
    output logic             sda_oe_o,       // Data drive enable, high while driving
    output logic             busy_o,         // Write cycle running
    output logic             soft_protect_o, // Soft protect bit
    output logic             ident_lock_o,   // Ident page locked
    output logic [7:0]       rd_data_o       // Array byte at rd_addr_i
);

    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam int PB = eeprom_wr_pkg::PAGE_BYTES;

    function automatic logic dev_match(input eeprom_wr_pkg::dev_byte_t b);
        dev_match = (b.type_code == eeprom_wr_pkg::TYPE_MEM) || (b.type_code == eeprom_wr_pkg::TYPE_SPECIAL);
    endfunction

    // ========================================================================
    // Link domain: capture each bit on the SCL rising edge
    logic bit_val_reg;
    logic bit_tgl_reg;

    always_ff @(posedge scl_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bit_val_reg <= 1'b0;
            bit_tgl_reg <= 1'b0;
        end
        else
        begin
            bit_val_reg <= sda_i;
            bit_tgl_reg <= ~bit_tgl_reg;
        end
    end

    // ========================================================================
    // Synchronisers and bus event detection
    logic [1:0] scl_s_reg;
    logic [1:0] sda_s_reg;
    logic [1:0] wp_s_reg;
    logic [1:0] tgl_s_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic       tgl_d_reg;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            scl_s_reg <= eeprom_wr_pkg::SYNC_HIGH_RST;
            sda_s_reg <= eeprom_wr_pkg::SYNC_HIGH_RST;
            wp_s_reg  <= 2'h0;
            tgl_s_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            tgl_d_reg <= 1'b0;
        end
        else
        begin
            scl_s_reg <= {scl_s_reg[0], scl_i};
            sda_s_reg <= {sda_s_reg[0], sda_i};
            wp_s_reg  <= {wp_s_reg[0], wp_i};
            tgl_s_reg <= {tgl_s_reg[0], bit_tgl_reg};
            scl_d_reg <= scl_s_reg[1];
            sda_d_reg <= sda_s_reg[1];
            tgl_d_reg <= tgl_s_reg[1];
        end
    end

    logic scl_hi;
    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic scl_fall;
    assign scl_hi   = scl_s_reg[1] & scl_d_reg;
    assign start_ev = scl_hi & sda_d_reg & ~sda_s_reg[1];
    assign stop_ev  = scl_hi & ~sda_d_reg & sda_s_reg[1];
    assign bit_ev   = tgl_s_reg[1] ^ tgl_d_reg;
    assign scl_fall = scl_d_reg & ~scl_s_reg[1];

    // ========================================================================
    // Byte assembly, MSB first
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] byte_in;
    logic       byte_done;
    logic       busy_reg;
    assign byte_in   = {shift_reg[6:0], bit_val_reg};
    assign byte_done = bit_ev && (bit_cnt_reg == eeprom_wr_pkg::BIT_LAST);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || start_ev || stop_ev || busy_reg)
            bit_cnt_reg <= 4'h0;
        else if (bit_ev)
            bit_cnt_reg <= (bit_cnt_reg == eeprom_wr_pkg::BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            shift_reg <= 8'h00;
        else if (bit_ev)
            shift_reg <= byte_in;
    end

    // ========================================================================
    // Command state
    eeprom_wr_pkg::state_t  state_reg;
    eeprom_wr_pkg::target_t target_reg;
    eeprom_wr_pkg::target_t commit_reg;
    logic [2:0]  dev_hi_reg;
    logic [10:0] addr_reg;
    logic        ack_reg;
    logic        armed_reg;
    logic        first_reg;
    logic        swp_reg;
    logic        lock_reg;
    logic        prot;
    logic        data_ok;
    logic        go_write;
    logic [7:0]  last_data_reg;
    logic [7:0]  page_buf [PB];
    logic [PB-1:0] bvalid_reg;

    assign prot = wp_s_reg[1] | swp_reg;

    always_comb
    begin
        case (target_reg)
            eeprom_wr_pkg::TGT_MEM:   data_ok = !prot;
            eeprom_wr_pkg::TGT_IDENT: data_ok = !prot && !lock_reg;
            eeprom_wr_pkg::TGT_LOCK:  data_ok = !prot && !lock_reg && byte_in[eeprom_wr_pkg::LOCK_DATA_BIT]
                                                && !first_reg;
            eeprom_wr_pkg::TGT_SWP:   data_ok = !first_reg;
            default:                  data_ok = 1'b0;
        endcase
    end

    // Stop one clock after the data acknowledge, no other bit in between
    assign go_write = stop_ev && armed_reg && (state_reg == eeprom_wr_pkg::ST_DATA)
                      && (bit_cnt_reg == eeprom_wr_pkg::BIT_STOP);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || busy_reg)
            state_reg <= eeprom_wr_pkg::ST_IDLE;
        else if (start_ev)
            state_reg <= eeprom_wr_pkg::ST_DEV;
        else if (stop_ev)
            state_reg <= eeprom_wr_pkg::ST_IDLE;
        else if (byte_done)
        begin
            case (state_reg)
                eeprom_wr_pkg::ST_DEV:
                    if (!dev_match(byte_in))
                        state_reg <= eeprom_wr_pkg::ST_IGNORE;
                    else if (byte_in[0])
                        state_reg <= eeprom_wr_pkg::ST_READ;
                    else
                        state_reg <= eeprom_wr_pkg::ST_WORD;
                eeprom_wr_pkg::ST_WORD:
                    state_reg <= eeprom_wr_pkg::ST_DATA;
                eeprom_wr_pkg::ST_DATA:
                    if (!data_ok)
                        state_reg <= eeprom_wr_pkg::ST_IGNORE;
                default:
                    state_reg <= state_reg;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || busy_reg)
            ack_reg <= 1'b0;
        else if (byte_done)
        begin
            case (state_reg)
                eeprom_wr_pkg::ST_DEV:  ack_reg <= dev_match(byte_in);
                eeprom_wr_pkg::ST_WORD: ack_reg <= 1'b1;
                eeprom_wr_pkg::ST_DATA: ack_reg <= data_ok;
                default:                ack_reg <= 1'b0;
            endcase
        end
    end

    // Address decode and page buffer fill
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            target_reg    <= eeprom_wr_pkg::TGT_MEM;
            dev_hi_reg    <= 3'h0;
            addr_reg      <= 11'h000;
            first_reg     <= 1'b0;
            bvalid_reg    <= '0;
            last_data_reg <= 8'h00;
        end
        else if (!busy_reg && byte_done)
        begin
            if (state_reg == eeprom_wr_pkg::ST_DEV)
            begin
                dev_hi_reg <= byte_in[3:1];
                target_reg <= (byte_in[7:4] == eeprom_wr_pkg::TYPE_MEM) ?
                              eeprom_wr_pkg::TGT_MEM : eeprom_wr_pkg::TGT_IDENT;
                first_reg  <= 1'b0;
                bvalid_reg <= '0;
            end
            else if (state_reg == eeprom_wr_pkg::ST_WORD)
            begin
                if (target_reg == eeprom_wr_pkg::TGT_MEM)
                    addr_reg <= {dev_hi_reg, byte_in};
                else
                begin
                    addr_reg <= {7'h00, byte_in[3:0]};
                    case (byte_in[7:6])
                        eeprom_wr_pkg::SEL_IDENT: target_reg <= eeprom_wr_pkg::TGT_IDENT;
                        eeprom_wr_pkg::SEL_UID:   target_reg <= eeprom_wr_pkg::TGT_UID;
                        eeprom_wr_pkg::SEL_LOCK:  target_reg <= eeprom_wr_pkg::TGT_LOCK;
                        default:                  target_reg <= eeprom_wr_pkg::TGT_SWP;
                    endcase
                end
            end
            else if (state_reg == eeprom_wr_pkg::ST_DATA && data_ok)
            begin
                first_reg                <= 1'b1;
                last_data_reg            <= byte_in;
                bvalid_reg[addr_reg[3:0]] <= 1'b1;
                addr_reg[3:0]            <= addr_reg[3:0] + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!busy_reg && byte_done && state_reg == eeprom_wr_pkg::ST_DATA && data_ok)
            page_buf[addr_reg[3:0]] <= byte_in;
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || start_ev || busy_reg)
            armed_reg <= 1'b0;
        else if (byte_done)
            armed_reg <= (state_reg == eeprom_wr_pkg::ST_DATA) && data_ok;
        else if (bit_ev && bit_cnt_reg == eeprom_wr_pkg::BIT_STOP)
            armed_reg <= 1'b0;
    end

    // ========================================================================
    // Acknowledge drive: low from the fall after bit eight to the fall after the ninth
    logic sda_oe_reg;
    logic sda_out_reg;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || busy_reg || start_ev || stop_ev)
            sda_oe_reg <= 1'b0;
        else if (scl_fall && bit_cnt_reg == eeprom_wr_pkg::BIT_ACK)
            sda_oe_reg <= ack_reg;
        else if (scl_fall && bit_cnt_reg == 4'h0)
            sda_oe_reg <= 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        sda_out_reg <= 1'b0;
    end

    // ========================================================================
    // Self-timed write cycle and commit
    logic [CW-1:0] wr_cnt_reg;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            busy_reg   <= 1'b0;
            wr_cnt_reg <= '0;
            commit_reg <= eeprom_wr_pkg::TGT_MEM;
        end
        else if (go_write)
        begin
            busy_reg   <= 1'b1;
            wr_cnt_reg <= CW'(WR_CYCLES - 1);
            commit_reg <= target_reg;
        end
        else if (busy_reg)
        begin
            wr_cnt_reg <= wr_cnt_reg - CW'(1);
            busy_reg   <= (wr_cnt_reg != '0);
        end
    end

    logic commit;
    assign commit = busy_reg && (wr_cnt_reg == '0);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            swp_reg  <= eeprom_wr_pkg::SOFT_PROT_RST;
            lock_reg <= eeprom_wr_pkg::IDENT_LOCK_RST;
        end
        else if (commit && commit_reg == eeprom_wr_pkg::TGT_SWP)
            swp_reg <= last_data_reg[eeprom_wr_pkg::PROT_VALUE_BIT];
        else if (commit && commit_reg == eeprom_wr_pkg::TGT_LOCK)
            lock_reg <= 1'b1;
    end

    logic [7:0] mem [eeprom_wr_pkg::MEM_BYTES];
    logic [7:0] ident_page [PB];

    // Each array has one writer; commit copies every buffered byte of the page at once
    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < PB; i++)
        begin
            if (commit && bvalid_reg[i] && commit_reg == eeprom_wr_pkg::TGT_MEM)
                mem[{addr_reg[10:4], 4'(i)}] <= page_buf[i];
        end
    end

    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < PB; i++)
        begin
            if (commit && bvalid_reg[i] && commit_reg == eeprom_wr_pkg::TGT_IDENT)
                ident_page[i] <= page_buf[i];
        end
    end

    always_ff @(posedge clock_i)
    begin
        rd_data_o <= mem[rd_addr_i];
    end

    // ========================================================================
    // Outputs
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            busy_o         <= 1'b0;
            soft_protect_o <= eeprom_wr_pkg::SOFT_PROT_RST;
            ident_lock_o   <= eeprom_wr_pkg::IDENT_LOCK_RST;
        end
        else
        begin
            busy_o         <= busy_reg;
            soft_protect_o <= swp_reg;
            ident_lock_o   <= lock_reg;
        end
    end

    assign sda_o    = sda_out_reg;
    assign sda_oe_o = sda_oe_reg;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    logic data_byte;
    logic [CW:0] busy_len_reg;
    assign data_byte = byte_done && !busy_reg && state_reg == eeprom_wr_pkg::ST_DATA;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || !busy_reg)
            busy_len_reg <= '0;
        else
            busy_len_reg <= busy_len_reg + (CW+1)'(1);
    end

    busy_quiet_a: assert property ($rose(sda_oe_reg) |-> !busy_reg)
        else $error("acknowledge driven during write cycle");
    busy_idle_a: assert property (busy_reg |=> state_reg == eeprom_wr_pkg::ST_IDLE)
        else $error("bus activity handled during write cycle");
    prot_nack_a: assert property (data_byte && prot && target_reg != eeprom_wr_pkg::TGT_SWP |=> !ack_reg)
        else $error("protected data byte acknowledged");
    free_ack_a: assert property (data_byte && !prot && target_reg == eeprom_wr_pkg::TGT_MEM |=> ack_reg)
        else $error("unprotected data byte refused");
    addr_wrap_a: assert property (data_byte && data_ok |=> addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1
                                  && addr_reg[10:4] == $past(addr_reg[10:4]))
        else $error("write address step wrong");
    stop_slot_a: assert property ($rose(busy_reg) |-> $past(stop_ev) && $past(bit_cnt_reg) == eeprom_wr_pkg::BIT_STOP)
        else $error("write cycle started off the stop slot");
    wr_len_a: assert property ($fell(busy_reg) |-> $past(busy_len_reg) == (CW+1)'(WR_CYCLES - 1))
        else $error("write cycle length wrong");
    lock_nack_a: assert property (data_byte && lock_reg && target_reg == eeprom_wr_pkg::TGT_LOCK |=> !ack_reg)
        else $error("lock data acknowledged after lock");
    ident_nack_a: assert property (data_byte && lock_reg && target_reg == eeprom_wr_pkg::TGT_IDENT |=> !ack_reg)
        else $error("locked ident data acknowledged");
    swp_once_a: assert property (data_byte && first_reg && target_reg == eeprom_wr_pkg::TGT_SWP |=> !armed_reg)
        else $error("second soft protect byte accepted");
    swp_pin_a: assert property (data_byte && !first_reg && target_reg == eeprom_wr_pkg::TGT_SWP |=> ack_reg)
        else $error("soft protect byte refused");
    dev_miss_a: assert property (byte_done && !busy_reg && state_reg == eeprom_wr_pkg::ST_DEV && !dev_match(byte_in)
                                 |=> !ack_reg && state_reg == eeprom_wr_pkg::ST_IGNORE)
        else $error("mismatched address handled");
    read_ack_a: assert property (byte_done && !busy_reg && state_reg == eeprom_wr_pkg::ST_DEV && dev_match(byte_in)
                                 && byte_in[0] |=> ack_reg && state_reg == eeprom_wr_pkg::ST_READ)
        else $error("read address not acknowledged");
    ident_store_a: assert property (commit && commit_reg == eeprom_wr_pkg::TGT_IDENT
                                    |=> ident_page[addr_reg[3:0] - 4'h1] == last_data_reg)
        else $error("ident page byte not stored");

    page_write_c: cover property (go_write && target_reg == eeprom_wr_pkg::TGT_MEM && bvalid_reg == '1);
    poll_nack_c: cover property (busy_reg && bit_ev);
    swp_write_c: cover property (commit && commit_reg == eeprom_wr_pkg::TGT_SWP);
    lock_write_c: cover property (commit && commit_reg == eeprom_wr_pkg::TGT_LOCK);

endmodule

`default_nettype wire

// ---- eeprom_wr_pkg.sv ----
// Purpose: Shared constants and types for the serial EEPROM write command logic
// Assumes: One word address byte after the device byte; A10..A8 ride in the device byte
// Notes:   Offsets, codes and counts live here, with the soft protect, lock and SCL/SDA sync reset values
`default_nettype none

package eeprom_wr_pkg;

    // ========================================================================
    // Address byte codes
    localparam logic [3:0] TYPE_MEM     = 4'ha;
    localparam logic [3:0] TYPE_SPECIAL = 4'hb;
    localparam logic [1:0] SEL_IDENT    = 2'h0;
    localparam logic [1:0] SEL_UID      = 2'h1;
    localparam logic [1:0] SEL_LOCK     = 2'h2;
    localparam logic [1:0] SEL_SWP      = 2'h3;
    localparam int         LOCK_DATA_BIT  = 1;
    localparam int         PROT_VALUE_BIT = 0;

    // ========================================================================
    // Bit counter positions within a nine clock byte slot
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_STOP = 4'h1;

    // ========================================================================
    // Sizes, counts and reset values
    localparam int         PAGE_BYTES     = 16;
    localparam int         MEM_BYTES      = 2048;
    localparam int         WR_CYCLES_DEF  = 1000;
    localparam logic       SOFT_PROT_RST  = 1'b0;
    localparam logic       IDENT_LOCK_RST = 1'b0;
    localparam logic [1:0] SYNC_HIGH_RST  = 2'h3;

    // ========================================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DEV    = 3'b001,
        ST_WORD   = 3'b010,
        ST_DATA   = 3'b011,
        ST_READ   = 3'b100,
        ST_IGNORE = 3'b101
    } state_t;

    typedef enum logic [2:0] {
        TGT_MEM   = 3'b000,
        TGT_IDENT = 3'b001,
        TGT_UID   = 3'b010,
        TGT_LOCK  = 3'b011,
        TGT_SWP   = 3'b100
    } target_t;

    typedef struct packed {
        logic [3:0] type_code;
        logic [2:0] hi_addr;
        logic       rd;
    } dev_byte_t;

endpackage

`default_nettype wire

// ---- i2c_master_model.sv ----
// Purpose: Behavioural two-wire bus master facing the EEPROM write logic
// Assumes: SDA is open drain with a pull-up, resolved in the bench
// Notes:   SCL stands high between frames; one bit slot is 160 ns
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    output logic      scl_o,   // Bus clock
    output logic      sda_m_o, // Master data level, 1 = released
    input  wire logic sda_i    // Resolved data line
);
    initial
    begin
        scl_o   = 1'b1;
        sda_m_o = 1'b1;
    end
    task automatic start();
        sda_m_o = 1'b1;
        #80 scl_o = 1'b1;
        #80 sda_m_o = 1'b0;
        #80 scl_o = 1'b0;
    endtask
    // Stop one clock after the last slot
    task automatic stop();
        #20 sda_m_o = 1'b0;
        #60 scl_o = 1'b1;
        #80 sda_m_o = 1'b1;
        #80;
    endtask
    task automatic bits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            #20 sda_m_o = v[i];
            #60 scl_o = 1'b1;
            #80 scl_o = 1'b0;
        end
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        bits(v, 8);
        #20 sda_m_o = 1'b1;
        #60 scl_o = 1'b1;
        #40 ack = ~sda_i;
        #40 scl_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- serial_eeprom_write_command_logic_test.sv ----
// Purpose: Self-checking bench for the EEPROM write command logic
// Assumes: Write cycle shortened to 50 clocks
// Notes:   Busy cycles are counted for every command
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_write_command_logic_test;
    localparam int WR = 50;
    typedef struct packed {logic [10:0] a; logic [7:0] d; logic wp; logic ack; logic [7:0] m;} row_t;
    localparam row_t ROWS [3] = '{'{11'h123, 8'h5a, 1'b0, 1'b1, 8'h5a},
        '{11'h123, 8'ha5, 1'b1, 1'b0, 8'h5a}, '{11'h7ff, 8'h3c, 1'b0, 1'b1, 8'h3c}};
    logic        clock_i, nrst_i, wp, k, scl, sda_m, sda, sda_o, sda_oe, busy, soft_protect_bit, lock;
    logic [10:0] rd_addr;
    logic [7:0]  rd_data;
    int          failures, total_checks, busy_base;
    int          busy_cnt = 0;
    assign sda = sda_m & ~(sda_oe & ~sda_o);
    i2c_master_model m (.scl_o(scl), .sda_m_o(sda_m), .sda_i(sda));
    eeprom_write_ctrl #(.WR_CYCLES(WR)) dut (.clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .wp_i(wp), .rd_addr_i(rd_addr), .sda_o(sda_o), .sda_oe_o(sda_oe), .busy_o(busy),
        .soft_protect_o(soft_protect_bit), .ident_lock_o(lock), .rd_data_o(rd_data));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
        if (busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic poll(input logic [7:0] dev, input logic e);
        m.start();
        m.send(dev, k);
        chk("address ack", {7'h0, e}, {7'h0, k});
    endtask
    task automatic cmd(input logic [7:0] dev, w, d, input int n, input logic ea, input int x);
        busy_base = busy_cnt;
        poll(dev, 1'b1);
        m.send(w, k);
        for (int i = 0; i < n; i++)
            m.send(d + 8'(i), k);
        chk("data ack", {7'h0, ea}, {7'h0, k});
        m.bits(8'hff, x);
        m.stop();
        repeat (6) @(negedge clock_i);
        for (int i = 0; i < 200 && busy === 1'b1; i++)
            @(negedge clock_i);
        chk("busy end", 8'h00, {7'h0, busy});
        if (busy !== 1'b0)
            summarize();
        chk("busy cycles", (ea && x == 0) ? 8'(WR) : 8'h00, 8'(busy_cnt - busy_base));
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        rd_addr = a;
        repeat (3) @(negedge clock_i);
        chk("memory", e, rd_data);
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        nrst_i = 1'b1;
        wp = 1'b0;
        rd_addr = 11'h000;
        failures = 0;
        total_checks = 0;
        busy_base = 0;
        // Real falling edge after time zero so the link-side flops reset
        #1 nrst_i = 1'b0;
        repeat (16) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (5) @(negedge clock_i);
        chk("reset outputs", 8'h00, {4'h0, busy, soft_protect_bit, lock, sda_oe});
        foreach (ROWS[i])
        begin
            wp = ROWS[i].wp;
            cmd({4'ha, ROWS[i].a[10:8], 1'b0}, ROWS[i].a[7:0], ROWS[i].d, 1, ROWS[i].ack, 0);
            rd(ROWS[i].a, ROWS[i].m);
        end
        wp = 1'b0;
        cmd(8'ha2, 8'h1e, 8'h40, 18, 1'b1, 0);
        rd(11'h11e, 8'h50);
        rd(11'h11f, 8'h51);
        rd(11'h110, 8'h42);
        rd(11'h11d, 8'h4f);
        cmd(8'ha4, 8'h40, 8'h11, 1, 1'b1, 2);
        busy_base = busy_cnt;
        poll(8'ha0, 1'b1);
        m.send(8'h00, k);
        m.send(8'h99, k);
        m.stop();
        poll(8'ha0, 1'b0);
        poll(8'ha1, 1'b1);
        m.stop();
        chk("write cycle", 8'(WR), 8'(busy_cnt - busy_base));
        rd(11'h000, 8'h99);
        wp = 1'b1;
        cmd(8'hb0, 8'hc0, 8'h01, 1, 1'b1, 0);
        chk("soft protect", 8'h01, {7'h0, soft_protect_bit});
        poll(8'hb1, 1'b1);
        poll(8'h50, 1'b0);
        m.stop();
        wp = 1'b0;
        cmd(8'ha0, 8'h05, 8'h66, 1, 1'b0, 0);
        cmd(8'hb0, 8'hc0, 8'h00, 2, 1'b0, 0);
        chk("soft protect kept", 8'h01, {7'h0, soft_protect_bit});
        cmd(8'hb0, 8'hc0, 8'hfe, 1, 1'b1, 0);
        chk("soft protect clear", 8'h00, {7'h0, soft_protect_bit});
        cmd(8'hb0, 8'h35, 8'h77, 1, 1'b1, 0);
        cmd(8'hb0, 8'h80, 8'hfd, 1, 1'b0, 0);
        chk("lock", 8'h00, {7'h0, lock});
        cmd(8'hb0, 8'h80, 8'h02, 1, 1'b1, 0);
        chk("lock", 8'h01, {7'h0, lock});
        cmd(8'hb0, 8'h80, 8'h02, 1, 1'b0, 0);
        cmd(8'hb0, 8'h00, 8'h12, 1, 1'b0, 0);
        // Mid-run reset with the bus idle clears lock and soft protect
        nrst_i = 1'b0;
        repeat (16) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (5) @(negedge clock_i);
        chk("reset again", 8'h00, {4'h0, busy, soft_protect_bit, lock, sda_oe});
        cmd(8'hb0, 8'h00, 8'h12, 1, 1'b1, 0);
        summarize();
    end
endmodule
`default_nettype wire
